/* bench/rom_controller_model.sv */
// Purpose: Behavioural speech controller that drives the ROM command pins.
// Assumes: Pins change just after a rise of clk, by non-blocking assignment.
// Notes: The serial input toggles when unused, so a stale bit never passes for data.
`timescale 1ns/1ps
module rom_controller_model (
    input wire logic clk,
    output logic romClock,
    output logic opCodeBitHi,
    output logic opCodeBitMid,
    output logic opCodeBitLo,
    output logic serialIn
);
    import serial_rom_pkg::*;

    initial begin
        romClock = 1'b0;
        {opCodeBitHi, opCodeBitMid, opCodeBitLo} = OP_IDLE_LOW;
        serialIn = 1'b0;
    end

    // ----------------------------------------------------------------
    // Command cycle
    // ----------------------------------------------------------------
    // one code per rise
    // Hold is the length of each ROM clock phase in clk cycles; 16 gives the nominal rate.
    task automatic send(input op_t op, input logic bitIn, input int hold);
        @(posedge clk);
        romClock <= 1'b1;
        {opCodeBitHi, opCodeBitMid, opCodeBitLo} <= op;
        serialIn <= (op == OP_LOAD_ADDRESS) ? bitIn : ~serialIn;
        repeat (hold) @(posedge clk);
        romClock <= 1'b0;
        repeat (hold) @(posedge clk);
        #1;
    endtask
endmodule

/* bench/tb.sv */
// Purpose: Self-checking bench of the serial command-port ROM.
// Assumes: Controller model drives the command pins; the bench owns selects and array loading.
// Notes: Internal registers are seen only through fetched bytes on the serial output.
`timescale 1ns/1ps
module tb;
    import serial_rom_pkg::*;

    logic clk, reset, romClock, opCodeBitHi, opCodeBitMid, opCodeBitLo, serialIn;
    logic outputGateShortN, selectHigh, selectLowN, progWrite;
    logic [10:0] progAddr;
    logic [7:0] progData;
    op_t lastOp;
    logic serialOut, serialOutEnable, fetchReady;
    wire romData;
    int nMismatch = 0;
    int comparisons = 0;

    assign romData = serialOutEnable ? serialOut : 1'bz;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    rom_controller_model i_ctrl (.clk(clk), .romClock(romClock), .opCodeBitHi(opCodeBitHi),
        .opCodeBitMid(opCodeBitMid), .opCodeBitLo(opCodeBitLo), .serialIn(serialIn));

    serial_rom_command_port i_dut (.clk(clk), .reset(reset), .romClock(romClock),
        .opCodeBitHi(opCodeBitHi), .opCodeBitMid(opCodeBitMid), .opCodeBitLo(opCodeBitLo),
        .serialIn(serialIn), .outputGateShortN(outputGateShortN), .selectHigh(selectHigh),
        .selectLowN(selectLowN), .progWrite(progWrite), .progAddr(progAddr), .progData(progData),
        .lastOp(lastOp), .serialOut(serialOut), .serialOutEnable(serialOutEnable),
        .fetchReady(fetchReady));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    function automatic logic [7:0] pat(input logic [10:0] a);
        return a[7:0] ^ {5'h00, a[10:8]} ^ 8'hA5;
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            nMismatch++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic cmd(input op_t op, input logic b = 1'b0, input int hold = 2);
        i_ctrl.send(op, b, hold);
        check("last code", lastOp, op);
    endtask

    task automatic load_address(input logic [15:0] a, input int n, input int hold);
        for (int i = 0; i < n; i++) begin
            cmd(OP_LOAD_ADDRESS, a[i], hold);
        end
    endtask

    task automatic read_byte(input logic [7:0] want);
        check("fetch ready", fetchReady, 1'b1);
        check("serial bit", serialOut, want[0]);
        for (int k = 1; k < 8; k++) begin
            cmd(OP_SHIFT_OUT);
            check("serial bit", serialOut, want[k]);
        end
    endtask

    task automatic prog(input logic [10:0] a);
        @(posedge clk);
        progWrite <= 1'b1;
        progAddr <= a;
        progData <= pat(a);
        @(posedge clk);
        progWrite <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // full load at nominal rate
    // The high address bits are set so that only the low 11 may select the byte.
    task automatic t_address_fetch();
        load_address(16'hF2A5, 16, 16);
        cmd(OP_SET_POINTER);
        cmd(OP_FETCH);
        read_byte(pat(11'h2A5));
        cmd(OP_FETCH);
        read_byte(pat(11'h2A6));
    endtask

    // partial address load
    // Four more bits push the old address down by four places.
    task automatic t_partial_load();
        load_address(16'h0003, 4, 2);
        cmd(OP_SET_POINTER);
        cmd(OP_FETCH);
        read_byte(pat(11'h72A));
    endtask

    task automatic t_save_restore();
        @(posedge clk);
        outputGateShortN <= 1'b1;
        load_address(16'h07FF, 16, 2);
        cmd(OP_IDLE_LOW, 1'b1);
        cmd(OP_IDLE_HIGH, 1'b1);
        cmd(OP_SET_POINTER);
        cmd(OP_SAVE_POINTER);
        cmd(OP_FETCH);
        cmd(OP_IDLE_LOW, 1'b1);
        cmd(OP_IDLE_HIGH, 1'b0);
        check("pin off", romData, 1'bz);
        read_byte(pat(11'h7FF));
        cmd(OP_FETCH);
        read_byte(pat(11'h000));
        cmd(OP_RESTORE_POINTER);
        cmd(OP_FETCH);
        read_byte(pat(11'h7FF));
    endtask

    task automatic t_gating();
        logic en;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {outputGateShortN, selectHigh, selectLowN} <= i[2:0];
            @(posedge clk);
            #1;
            en = (i[2:0] == 3'b010);
            check("output enable", serialOutEnable, en);
            check("pin level", romData, en ? serialOut : 1'bz);
        end
    endtask

    // ----------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
        if (nMismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        outputGateShortN = 1'b0;
        selectHigh = 1'b1;
        selectLowN = 1'b0;
        progWrite = 1'b0;
        progAddr = 11'h000;
        progData = 8'h00;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        prog(11'h000);
        prog(11'h7FF);
        prog(11'h2A5);
        prog(11'h2A6);
        prog(11'h72A);
        t_address_fetch();
        t_partial_load();
        t_save_restore();
        t_gating();
        give_verdict();
    end

    // A full run needs about 1,000 cycles; the limit leaves ample margin.
    initial begin
        repeat (20000) @(posedge clk);
        nMismatch++;
        give_verdict();
    end
endmodule

/* hw/byte_stream_if.sv */
// Purpose: Valid/ready carrier for bytes between the ROM's own modules.
// Assumes: One clock domain.
// Notes: A word moves on a cycle where valid and ready are both high.
`timescale 1ns/1ps
interface byte_stream_if #(
    parameter int W = 8
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport source (
        output valid,
        output data,
        input ready
    );

    modport sink (
        input valid,
        input data,
        output ready
    );
endinterface

/* hw/serial_rom_command_port.sv */
// Purpose: Serial-access ROM with a three-bit command port and gated serial output.
// Assumes: All pins synchronous to clk; the ROM clock is sampled, not used as a clock.
// Notes: The array is loaded through the program port after reset.
// Function
// RULE1: Decode three control pins as one code; codes 000 and 111 do nothing.
// RULE2: Code 001 takes one serial input bit per ROM clock cycle.
// RULE3: Bits taken under code 001 shift into the address shift register.
// RULE4: Address shift register is 16 bits and keeps its value between loads.
// RULE5: Controller sends the 16-bit start address serially with code 001.
// RULE6: Code 010 copies the address shift register into the word pointer.
// RULE7: Code 011 fetches the byte at the low pointer bits into data shift.
// RULE8: After each fetch completes the word pointer increments by one.
// RULE9: Code 100 shifts the data shift register out, one bit per ROM clock.
// RULE10: Code 101 copies the word pointer into the return pointer.
// RULE11: Code 110 reloads the word pointer from the return pointer.
// RULE12: Output gate high turns the serial output off.
// RULE13: Active-high select low turns the serial output off.
// RULE14: Active-low select high turns the serial output off.
// RULE15: Output gating follows the selects without waiting for the ROM clock.
// RULE16: Controller supplies the ROM clock at a nominal 1.56 MHz.
// RULE17: Code and serial input sampled on ROM clock rise; bits least significant first.
// RULE18: Register operations run whatever the selects; selects gate only the output.
`timescale 1ns/1ps
`include "serial_rom_regs.svh"
module serial_rom_command_port #(
    parameter int ADDR_W = `SROM_ADDR_W,
    parameter int POINTER_W = `SROM_POINTER_W,
    parameter int BUFFER_DEPTH = `SROM_BUFFER_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic romClock,
    input wire logic opCodeBitHi,
    input wire logic opCodeBitMid,
    input wire logic opCodeBitLo,
    input wire logic serialIn,
    input wire logic outputGateShortN,
    input wire logic selectHigh,
    input wire logic selectLowN,
    input wire logic progWrite,
    input wire logic [ADDR_W-1:0] progAddr,
    input wire logic [`SROM_DATA_W-1:0] progData,
    output serial_rom_pkg::op_t lastOp,
    output logic serialOut,
    output logic serialOutEnable,
    output logic fetchReady
);
    import serial_rom_pkg::*;

    localparam int DW = `SROM_DATA_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int GATE_CYC = `SROM_T_OUTPUT_GATE_CYC;

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] rom;
        logic [POINTER_W-1:0] addressShiftReg;
        logic [POINTER_W-1:0] wordPointer;
        logic [POINTER_W-1:0] returnPointer;
        logic [DW-1:0] dataShift;
        logic romClockPrev;
        op_t lastOp;
        logic serialOut;
        logic serialOutEnable;
        logic fetchReady;
    } state_t;

    state_t state;
    state_t next_state;
    op_t opCode;
    logic romEdge;
    logic fetchTaken;
    logic shiftEdge;

    byte_stream_if #(.W(DW)) fetchStream();
    byte_stream_if #(.W(DW)) dsrStream();

    // ----------------------------------------------------------------
    // Command sampling
    // ----------------------------------------------------------------
    // RULE1 code decode
    assign opCode = op_t'({opCodeBitHi, opCodeBitMid, opCodeBitLo});
    // RULE17 rising edge
    assign romEdge = romClock && !state.romClockPrev;
    assign shiftEdge = romEdge && (opCode == OP_SHIFT_OUT);

    // ----------------------------------------------------------------
    // Fetch path
    // ----------------------------------------------------------------
    // A full buffer refuses the fetch; the pointer then stays put so no byte is skipped.
    // RULE7 array read
    assign fetchStream.valid = romEdge && (opCode == OP_FETCH);
    assign fetchStream.data = state.rom[state.wordPointer[ADDR_W-1:0]];
    assign fetchTaken = fetchStream.valid && fetchStream.ready;
    // The data shift register is busy while a shift-out sequence is under way.
    assign dsrStream.ready = !shiftEdge && (state.lastOp != OP_SHIFT_OUT);

    two_entry_buffer #(
        .W(DW),
        .DEPTH(BUFFER_DEPTH)
    ) fetchBuffer (
        .clk(clk),
        .reset(reset),
        .fill(fetchStream.sink),
        .drain(dsrStream.source)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        // RULE4 registers hold
        next_state = state;
        next_state.romClockPrev = romClock;
        if (progWrite) begin
            next_state.rom[progAddr] = progData;
        end
        // RULE18 selects ignored here
        if (romEdge) begin
            next_state.lastOp = opCode;
            case (opCode)
                OP_LOAD_ADDRESS: begin
                    // RULE2 serial bit taken
                    // RULE3 shift into address
                    next_state.addressShiftReg = {serialIn, state.addressShiftReg[POINTER_W-1:1]};
                end
                OP_SET_POINTER: begin
                    // RULE6 pointer load
                    next_state.wordPointer = state.addressShiftReg;
                end
                OP_FETCH: begin
                    // RULE8 post increment
                    if (fetchTaken) begin
                        next_state.wordPointer = state.wordPointer + POINTER_W'(1);
                    end
                end
                OP_SHIFT_OUT: begin
                    // RULE9 shift one bit
                    next_state.dataShift = {1'b0, state.dataShift[DW-1:1]};
                end
                OP_SAVE_POINTER: begin
                    // RULE10 save pointer
                    next_state.returnPointer = state.wordPointer;
                end
                OP_RESTORE_POINTER: begin
                    // RULE11 restore pointer
                    next_state.wordPointer = state.returnPointer;
                end
                default: begin
                end
            endcase
        end
        if (dsrStream.valid && dsrStream.ready) begin
            next_state.dataShift = dsrStream.data;
        end
        next_state.serialOut = next_state.dataShift[0];
        // RULE15 independent of romEdge
        // RULE12 RULE13 RULE14 output gate
        next_state.serialOutEnable = !outputGateShortN && selectHigh && !selectLowN;
        next_state.fetchReady = fetchStream.ready;
        // A ROM clock held high through reset reads as a rise on the first cycle after it.
        if (reset) begin
            next_state = '0;
            next_state.addressShiftReg = POINTER_W'(`SROM_POINTER_RESET);
            next_state.wordPointer = POINTER_W'(`SROM_POINTER_RESET);
            next_state.returnPointer = POINTER_W'(`SROM_POINTER_RESET);
            next_state.dataShift = DW'(`SROM_DATA_RESET);
            next_state.lastOp = OP_IDLE_LOW;
        end
    end

    always_ff @(posedge clk) begin
        state <= next_state;
    end

    assign lastOp = state.lastOp;
    assign serialOut = state.serialOut;
    assign serialOutEnable = state.serialOutEnable;
    assign fetchReady = state.fetchReady;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_idle_codes_hold: assert property ( // RULE1
        romEdge && (opCode == OP_IDLE_LOW || opCode == OP_IDLE_HIGH) && !(dsrStream.valid && dsrStream.ready)
        |=> $stable(state.addressShiftReg) && $stable(state.wordPointer)
            && $stable(state.returnPointer) && $stable(state.dataShift))
        else $error("idle code changed a register");

    a_address_shift_in: assert property ( // RULE3
        romEdge && opCode == OP_LOAD_ADDRESS
        |=> state.addressShiftReg == {$past(serialIn), $past(state.addressShiftReg[POINTER_W-1:1])})
        else $error("address shift register did not take the serial bit");

    a_address_kept: assert property ( // RULE4
        !(romEdge && opCode == OP_LOAD_ADDRESS) |=> $stable(state.addressShiftReg))
        else $error("address shift register changed outside a load");

    a_pointer_load: assert property ( // RULE6
        romEdge && opCode == OP_SET_POINTER |=> state.wordPointer == $past(state.addressShiftReg))
        else $error("word pointer not loaded from address register");

    a_fetch_increment: assert property ( // RULE8
        fetchTaken |=> state.wordPointer == $past(state.wordPointer) + POINTER_W'(1))
        else $error("word pointer did not advance after fetch");

    a_fetch_reaches_dsr: assert property ( // RULE7
        fetchTaken && dsrStream.ready && !dsrStream.valid
        ##1 dsrStream.ready[*2] |=> state.dataShift == $past(fetchStream.data, 3))
        else $error("fetched byte did not reach the data shift register");

    a_shift_out_bit: assert property ( // RULE9
        shiftEdge |=> state.dataShift == ($past(state.dataShift) >> 1) ##1 serialOut == $past(state.dataShift[0]))
        else $error("data shift register did not shift one bit");

    a_save_pointer: assert property ( // RULE10
        romEdge && opCode == OP_SAVE_POINTER |=> state.returnPointer == $past(state.wordPointer))
        else $error("return pointer not saved");

    a_restore_pointer: assert property ( // RULE11
        romEdge && opCode == OP_RESTORE_POINTER |=> state.wordPointer == $past(state.returnPointer))
        else $error("word pointer not restored");

    a_gate_turns_off: assert property ( // RULE12
        outputGateShortN [*2] |-> ##[0:GATE_CYC] !serialOutEnable)
        else $error("output gate high left the output driven");

    a_select_high_off: assert property ( // RULE13
        !selectHigh [*2] |-> ##[0:GATE_CYC] !serialOutEnable)
        else $error("select high low left the output driven");

    a_select_low_off: assert property ( // RULE14
        selectLowN [*2] |-> ##[0:GATE_CYC] !serialOutEnable)
        else $error("select low high left the output driven");

    a_enable_no_clock: assert property ( // RULE15
        (!outputGateShortN && selectHigh && !selectLowN && $stable(romClock)) [*2]
        |-> serialOutEnable)
        else $error("output enable waited for the ROM clock");

    // ----------------------------------------------------------------
    // Retention and ordering checks
    // ----------------------------------------------------------------
    // Retention checks catch a stray write at once, not only when a later fetch reads it back.
    a_bit_taken: assert property ( // RULE2
        romEdge && opCode == OP_LOAD_ADDRESS
        |=> state.addressShiftReg[POINTER_W-1] == $past(serialIn))
        else $error("serial input bit not taken on the command edge");

    a_shift_deselected: assert property ( // RULE18
        shiftEdge && !serialOutEnable
        |=> state.dataShift == ($past(state.dataShift) >> 1))
        else $error("shift did not run while the output was off");

    a_serial_mirror: assert property ( // RULE9
        !reset
        |-> serialOut == state.dataShift[0])
        else $error("serial output does not show bit 0 of the data shift register");

    a_dsr_held: assert property ( // RULE9
        state.lastOp == OP_SHIFT_OUT && !shiftEdge
        |=> $stable(state.dataShift))
        else $error("data shift register changed between shift edges");

    a_reset_off: assert property ( // RULE12
        $fell(reset)
        |-> !serialOutEnable && state.wordPointer == '0 && state.returnPointer == '0)
        else $error("output or pointers not cleared by reset");

    a_rise_detect: assert property ( // RULE17
        $rose(romClock)
        |-> romEdge)
        else $error("ROM clock rise not taken as a command edge");

    a_lastop_tracks: assert property ( // RULE1
        romEdge
        |=> lastOp == $past(opCode))
        else $error("status code does not follow the command edge");

    a_return_kept: assert property ( // RULE10
        !(romEdge && opCode == OP_SAVE_POINTER)
        |=> $stable(state.returnPointer))
        else $error("return pointer changed outside a save");

    a_pointer_kept: assert property ( // RULE6
        !(romEdge && (opCode == OP_SET_POINTER || opCode == OP_FETCH || opCode == OP_RESTORE_POINTER))
        |=> $stable(state.wordPointer))
        else $error("word pointer changed without a pointer command");

    a_save_keeps_pointer: assert property ( // RULE10
        romEdge && opCode == OP_SAVE_POINTER
        |=> $stable(state.wordPointer) && $stable(state.addressShiftReg))
        else $error("save disturbed the word pointer");

    a_fetch_keeps_regs: assert property ( // RULE7
        fetchTaken
        |=> $stable(state.addressShiftReg) && $stable(state.returnPointer))
        else $error("fetch disturbed the address or return register");

    a_lsb_first: assert property ( // RULE17
        dsrStream.valid && dsrStream.ready
        |=> serialOut == $past(dsrStream.data[0]))
        else $error("loaded byte did not show its lowest bit first");
endmodule

/* hw/serial_rom_pkg.sv */
// Purpose: Types shared by the serial command-port ROM.
// Assumes: Nothing beyond the header of constants.
// Notes: Operation codes follow the three control pins, high bit first.
package serial_rom_pkg;

    // ----------------------------------------------------------------
    // Operation codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_IDLE_LOW = 3'h0,
        OP_LOAD_ADDRESS = 3'h1,
        OP_SET_POINTER = 3'h2,
        OP_FETCH = 3'h3,
        OP_SHIFT_OUT = 3'h4,
        OP_SAVE_POINTER = 3'h5,
        OP_RESTORE_POINTER = 3'h6,
        OP_IDLE_HIGH = 3'h7
    } op_t;

endpackage

/* hw/serial_rom_regs.svh */
// Purpose: Widths and timing counts of the serial command-port ROM.
// Assumes: System clock of 50 MHz; the ROM clock arrives as a plain input.
// Notes: Definitions only.
`ifndef SERIAL_ROM_REGS_SVH
`define SERIAL_ROM_REGS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SROM_POINTER_W 16
`define SROM_DATA_W 8
`define SROM_ADDR_W 11
`define SROM_BUFFER_DEPTH 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SROM_POINTER_RESET 16'h0000
`define SROM_DATA_RESET 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SROM_CLK_NS 20
`define SROM_ROM_CLOCK_KHZ 1560
`define SROM_T_OUTPUT_GATE_NS 120
// Longest time, so it rounds down.
`define SROM_T_OUTPUT_GATE_CYC (`SROM_T_OUTPUT_GATE_NS / `SROM_CLK_NS)

`endif

/* hw/two_entry_buffer.sv */
// Purpose: Small FIFO between the array read and the data shift register.
// Assumes: Synchronous active-high reset.
// Notes: Ready on the fill side falls only when every entry is taken.
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic reset,
    byte_stream_if.sink fill,
    byte_stream_if.source drain
);
    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [IW-1:0] wr;
        logic [IW-1:0] rd;
        logic [CW-1:0] count;
    } buffer_t;

    buffer_t state;
    buffer_t next_state;
    logic push;
    logic pop;

    // ----------------------------------------------------------------
    // Handshake
    // ----------------------------------------------------------------
    assign fill.ready = (state.count != CW'(DEPTH));
    assign drain.valid = (state.count != '0);
    assign drain.data = state.mem[state.rd];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (push) begin
            next_state.mem[state.wr] = fill.data;
            next_state.wr = (state.wr == IW'(DEPTH - 1)) ? '0 : state.wr + IW'(1);
        end
        if (pop) begin
            next_state.rd = (state.rd == IW'(DEPTH - 1)) ? '0 : state.rd + IW'(1);
        end
        if (push && !pop) begin
            next_state.count = state.count + CW'(1);
        end else if (pop && !push) begin
            next_state.count = state.count - CW'(1);
        end
        if (reset) begin
            next_state = '0;
        end
    end

    always_ff @(posedge clk) begin
        state <= next_state;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_buffer_no_overflow: assert property (@(posedge clk) disable iff (reset)
        state.count <= CW'(DEPTH))
        else $error("buffer count above its depth");
endmodule
